/* rtl/sls_pkg.sv */
// Constants shared by the synchronous line adapter design files.
package sls_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int FIXED_RATE_BPS = 56000;
  localparam int FIXED_DIV = CLK_HZ / FIXED_RATE_BPS;
  localparam int DIV_W = 12;
  localparam int TX_DEPTH = 64;
  localparam int CHAR_W = 8;
  // Register numbers on the line register port.
  localparam logic [2:0] REG_DATA = 3'h1;
  localparam logic [2:0] REG_CONTROL = 3'h2;
  localparam logic [2:0] REG_CHAR4 = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [2:0] REG_CONFIG = 3'h6;
  // Channel select on the line register port.
  localparam logic CHAN_RX = 1'b0;
  localparam logic CHAN_TX = 1'b1;
  // Bit n of a line register, counted from the left, is vector index 7 - n.
  localparam int ST_DSR = 7;
  localparam int ST_CTS = 6;
  localparam int ST_CARRIER = 5;
  localparam int ST_RING = 4;
  localparam int ST_READY = 3;
  localparam int ST_TXEMPTY = 2;
  localparam int ST_RXOVR = 1;
  localparam int ST_TXUR = 0;
  localparam int CT_DTR = 7;
  localparam int CT_RTS = 6;
  localparam int CT_DIRECT = 3;
  localparam int CT_LOOP = 2;
  localparam int CT_RXON = 1;
  localparam int CT_TXON = 0;
  localparam int CF_LEN_HI = 7;
  localparam int CF_LEN_LO = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] FILL_RESET = 8'h16;
  localparam logic [3:0] BASE_LEN = 4'h5;
  localparam logic [3:0] BITS_ZERO = 4'h0;
  localparam logic [3:0] BITS_ONE = 4'h1;
  localparam logic [1:0] SYNC_ZERO = 2'h0;
  typedef enum logic {SLS_IDLE, SLS_SHIFT} sls_tx_state_t;
endpackage

/* rtl/sls_fifo.sv */
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module sls_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [PW:0] count_r, count_nxt;
  logic push, pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  always_comb
  begin
    inReady = (count_r != FULL_COUNT);
    outValid = (count_r != '0);
    outData = mem_r[rdPtr_r];
    push = inValid && inReady;
    pop = outValid && outReady;
    wrPtr_nxt = push ? bump(wrPtr_r) : wrPtr_r;
    rdPtr_nxt = pop ? bump(rdPtr_r) : rdPtr_r;
    count_nxt = count_r;
    if (push && !pop)
    begin
      count_nxt = count_r + 1'b1;
    end
    else if (pop && !push)
    begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

  // Storage has no reset; an empty FIFO never presents it as valid.
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_r[wrPtr_r] <= inData;
    end
  end
endmodule

/* rtl/sls_line_adapter.sv */
// Line registers, status, transmit buffer and transmit serialiser of a sync line adapter.
`timescale 1ns/100ps
// Summary of operation
// - One 8-bit status register serves both channels; modem status low, adapter flags high.
// - Status reads through the register port never change the status contents.
// - Modem bits: 0 interlock/DSR, 1 CTS, 2 carrier/gain lock, 3 ring/call.
// - Character configuration register is shared; either channel's write affects both.
// - Character length for both channels comes from configuration bits 0 and 1.
// - Parity and check selections in the configuration byte are ignored.
// - Each transmit data register write that finds room goes into a 64-byte transmit buffer.
// - Adapter-ready status bit tells the processor whether the buffer has room.
// - Short characters are right-justified; leading zero bits are not sent.
// - Bit 7 of each transmit character goes out on the line first.
// - Fill character is sent during idle time and on buffer underrun.
// - Data-set and adapter control register is shared by both channels.
// - Receive channel requests are raised only while receive-on is set.
// - Transmit channel requests are raised only while transmit-on is set.
// - Transmit requests also need request-to-send set and clear-to-send reported.
// - Transmit adapter-ready is true exactly when the buffer is not full.
// - Each character boundary moves the next buffered character out and requests more.
module sls_line_adapter (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regChannel,
  input wire logic [2:0] regNum,
  input wire logic [sls_pkg::CHAR_W-1:0] regWData,
  output logic [sls_pkg::CHAR_W-1:0] regRData,
  output logic regRValid,
  input wire logic dsrPin,
  input wire logic ctsPin,
  input wire logic carrierPin,
  input wire logic ringPin,
  input wire logic txClockPin,
  input wire logic rxCharReady,
  input wire logic rxOverrunSet,
  output logic txDataPin,
  output logic rtsPin,
  output logic dtrPin,
  output logic rxRequest,
  output logic txRequest,
  output logic [sls_pkg::CHAR_W-1:0] controlOut,
  output logic [sls_pkg::CHAR_W-1:0] syncChar
);
  import sls_pkg::*;

  logic [3:0] pinMeta_r, pinSync_r;
  logic clkMeta_r, clkSync_r, clkPrev_r;
  logic [7:0] control_r, control_nxt, config_r, config_nxt, fill_r, fill_nxt;
  logic [7:0] sync_r, sync_nxt, shift_r, shift_nxt, rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt, underrun_r, underrun_nxt, overrun_r, overrun_nxt;
  logic line_r, line_nxt, rxReq_r, rxReq_nxt, txReq_r, txReq_nxt;
  logic [3:0] bitsLeft_r, bitsLeft_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  sls_tx_state_t state_r, state_nxt;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  logic [7:0] fifoOutData, status;
  logic bitTick, divTick, wrTx, boundary;

  // Length field 00..11 selects 5..8 bits; parity and check fields are never looked at.
  function automatic logic [3:0] char_len(input logic [7:0] cfg);
    char_len = BASE_LEN + {2'h0, cfg[CF_LEN_HI:CF_LEN_LO]};
  endfunction

  function automatic logic reg_hit(input logic [2:0] num, input logic [2:0] want);
    reg_hit = (num == want);
  endfunction

  sls_fifo #(.WIDTH(CHAR_W), .DEPTH(TX_DEPTH)) txBuffer (
    .clk_sys(clk_sys),
    .reset(reset),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(regWData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // Modem pins and the modem's transmit clock are asynchronous, so each passes two flops.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
      clkMeta_r <= 1'b0;
      clkSync_r <= 1'b0;
      clkPrev_r <= 1'b0;
    end
    else
    begin
      pinMeta_r <= {dsrPin, ctsPin, carrierPin, ringPin};
      pinSync_r <= pinMeta_r;
      clkMeta_r <= txClockPin;
      clkSync_r <= clkMeta_r;
      clkPrev_r <= clkSync_r;
    end
  end

  always_comb
  begin
    wrTx = regWrite && (regChannel == CHAN_TX);
    divTick = (div_r == '0);
    div_nxt = divTick ? DIV_W'(FIXED_DIV - 1) : div_r - 1'b1;
    // Direct connect and loop-back run from the fixed-rate divider, else the modem clock.
    if (control_r[CT_DIRECT] || control_r[CT_LOOP])
    begin
      bitTick = divTick;
    end
    else
    begin
      bitTick = clkSync_r && !clkPrev_r;
    end
    status = '0;
    status[ST_DSR] = pinSync_r[3];
    status[ST_CTS] = pinSync_r[2];
    status[ST_CARRIER] = pinSync_r[1];
    status[ST_RING] = pinSync_r[0];
    status[ST_READY] = fifoInReady;
    status[ST_TXEMPTY] = !fifoOutValid;
    status[ST_RXOVR] = overrun_r;
    status[ST_TXUR] = underrun_r;
  end

  always_comb
  begin
    // Shared registers ignore which channel wrote them.
    control_nxt = (regWrite && reg_hit(regNum, REG_CONTROL)) ? regWData : control_r;
    config_nxt = (regWrite && reg_hit(regNum, REG_CONFIG)) ? regWData : config_r;
    fill_nxt = (wrTx && reg_hit(regNum, REG_CHAR4)) ? regWData : fill_r;
    sync_nxt = (regWrite && !regChannel && reg_hit(regNum, REG_CHAR4)) ? regWData : sync_r;
    // A write to a full buffer is dropped; software must test adapter-ready first.
    fifoInValid = wrTx && reg_hit(regNum, REG_DATA);
    rvalid_nxt = regRead;
    rdata_nxt = rdata_r;
    if (regRead)
    begin
      rdata_nxt = reg_hit(regNum, REG_STATUS) ? status : RESET_BYTE;
      if (reg_hit(regNum, REG_CONTROL))
      begin
        rdata_nxt = control_r;
      end
      else if (reg_hit(regNum, REG_CONFIG))
      begin
        rdata_nxt = config_r;
      end
    end
  end

  always_comb
  begin
    // Flags clear while their channel is off; a new event in that cycle still sets them.
    overrun_nxt = rxOverrunSet || (overrun_r && control_r[CT_RXON]);
    boundary = bitTick && (bitsLeft_r == BITS_ZERO);
    fifoOutReady = boundary && control_r[CT_TXON] && !control_r[CT_LOOP];
    underrun_nxt = (fifoOutReady && !fifoOutValid && state_r == SLS_SHIFT)
      || (underrun_r && control_r[CT_TXON]);
  end

  always_comb
  begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bitsLeft_nxt = bitsLeft_r;
    line_nxt = line_r;
    if (!control_r[CT_TXON] || control_r[CT_LOOP])
    begin
      // Transmitter off or looped back: line held at mark, nothing leaves the buffer.
      state_nxt = SLS_IDLE;
      bitsLeft_nxt = BITS_ZERO;
      line_nxt = 1'b1;
    end
    else if (bitTick)
    begin
      unique case (state_r)
        SLS_IDLE, SLS_SHIFT:
        begin
          if (boundary)
          begin
            shift_nxt = fifoOutValid ? fifoOutData : fill_r;
            state_nxt = fifoOutValid ? SLS_SHIFT : state_r;
            bitsLeft_nxt = char_len(config_r) - BITS_ONE;
            line_nxt = shift_nxt[0];
            shift_nxt = {1'b0, shift_nxt[7:1]};
          end
          else
          begin
            line_nxt = shift_r[0];
            shift_nxt = {1'b0, shift_r[7:1]};
            bitsLeft_nxt = bitsLeft_r - BITS_ONE;
          end
        end
      endcase
    end
  end

  always_comb
  begin
    rxReq_nxt = control_r[CT_RXON] && rxCharReady;
    txReq_nxt = control_r[CT_TXON] && control_r[CT_RTS]
      && pinSync_r[2] && fifoInReady;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      control_r <= RESET_BYTE;
      config_r <= RESET_BYTE;
      fill_r <= FILL_RESET;
      sync_r <= FILL_RESET;
      rdata_r <= RESET_BYTE;
      rvalid_r <= 1'h0;
    end
    else
    begin
      control_r <= control_nxt;
      config_r <= config_nxt;
      fill_r <= fill_nxt;
      sync_r <= sync_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      overrun_r <= 1'h0;
      underrun_r <= 1'h0;
    end
    else
    begin
      overrun_r <= overrun_nxt;
      underrun_r <= underrun_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_r <= SLS_IDLE;
      shift_r <= RESET_BYTE;
      bitsLeft_r <= BITS_ZERO;
      line_r <= 1'h1;
    end
    else
    begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bitsLeft_r <= bitsLeft_nxt;
      line_r <= line_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rxReq_r <= 1'h0;
      txReq_r <= 1'h0;
    end
    else
    begin
      rxReq_r <= rxReq_nxt;
      txReq_r <= txReq_nxt;
    end
  end

  // The divider runs free in every mode, so entering direct connect waits at most one bit time.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= div_nxt;
    end
  end

  always_comb
  begin
    regRData = rdata_r;
    regRValid = rvalid_r;
    txDataPin = line_r;
    rtsPin = control_r[CT_RTS];
    dtrPin = control_r[CT_DTR];
    rxRequest = rxReq_r;
    txRequest = txReq_r;
    controlOut = control_r;
    syncChar = sync_r;
  end
endmodule

/* tb/sls_line_adapter_assertions.sv */
// Concurrent port checks for the sync line adapter.
`timescale 1ns/100ps
module sls_line_adapter_assertions (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [2:0] regNum,
  input wire logic [sls_pkg::CHAR_W-1:0] regWData,
  input wire logic [sls_pkg::CHAR_W-1:0] regRData,
  input wire logic regRValid,
  input wire logic ctsPin,
  input wire logic rxCharReady,
  input wire logic rtsPin,
  input wire logic rxRequest,
  input wire logic txRequest,
  input wire logic [sls_pkg::CHAR_W-1:0] controlOut
);
  import sls_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_rv; regRead |=> regRValid; endproperty
  a_rv: assert property (p_rv) else $error("read answer missing");
  property p_rvo; !regRead |=> !regRValid; endproperty
  a_rvo: assert property (p_rvo) else $error("stray read answer");
  // The pin guard allows for the synchroniser delay ahead of the status register.
  property p_cts; regRead && regNum == REG_STATUS && $past(ctsPin, 4) == ctsPin
    |=> regRData[ST_CTS] == $past(ctsPin); endproperty
  a_cts: assert property (p_cts) else $error("status cts wrong");
  property p_ctl; regWrite && regNum == REG_CONTROL |=> controlOut == $past(regWData); endproperty
  a_ctl: assert property (p_ctl) else $error("control write lost");
  property p_hold; !regWrite |=> $stable(controlOut); endproperty
  a_hold: assert property (p_hold) else $error("control changed");
  property p_rts; rtsPin == controlOut[CT_RTS]; endproperty
  a_rts: assert property (p_rts) else $error("rts pin wrong");
  property p_rxq; rxRequest == $past(controlOut[CT_RXON] && rxCharReady); endproperty
  a_rxq: assert property (p_rxq) else $error("rx request wrong");
  property p_txq; txRequest |-> $past(controlOut[CT_TXON] && controlOut[CT_RTS]); endproperty
  a_txq: assert property (p_txq) else $error("tx request wrong");
  c_txq: cover property (txRequest);
  c_rxq: cover property (rxRequest);
  c_st: cover property (regRead && regNum == REG_STATUS);
endmodule
bind sls_line_adapter sls_line_adapter_assertions u_chk (.clk_sys(clk_sys), .reset(reset),
  .regWrite(regWrite), .regRead(regRead), .regNum(regNum), .regWData(regWData),
  .regRData(regRData), .regRValid(regRValid), .ctsPin(ctsPin), .rxCharReady(rxCharReady),
  .rtsPin(rtsPin), .rxRequest(rxRequest), .txRequest(txRequest), .controlOut(controlOut));

/* tb/sls_modem_model.sv */
// Modem model: free-running transmit clock and capture of one sent character.
`timescale 1ns/100ps
module sls_modem_model (
  input wire logic clr,
  input wire logic [3:0] len,
  input wire logic txDataPin,
  output logic txClockPin,
  output logic [7:0] got,
  output logic done
);
  logic [3:0] cnt;
  initial
  begin
    txClockPin = 1'h0;
    #13;
    forever #40 txClockPin = ~txClockPin;
  end
  // A character opens with a 0 against all-ones fill, so fill must keep every bit it sends high.
  always @(posedge txClockPin or posedge clr)
  begin
    if (clr)
      cnt <= 4'h0;
    else if ((cnt == 4'h0 && !txDataPin) || (cnt != 4'h0 && cnt < len))
    begin
      got <= {txDataPin, got[7:1]};
      cnt <= cnt + 4'h1;
    end
  end
  assign done = (cnt == len);
endmodule

/* tb/tb.sv */
// Self-checking bench for the sync line adapter.
`timescale 1ns/100ps
module tb;
  import sls_pkg::*;
  logic clk_sys, reset, regWrite, regRead, regChannel, regRValid, clr, done;
  logic [2:0] regNum;
  logic [7:0] regWData, regRData, controlOut, got, rdv, syncChar;
  logic dsrPin, ctsPin, carrierPin, ringPin, txClockPin, rxCharReady, rxOverrunSet;
  logic txDataPin, rxRequest, txRequest, dtrPin;
  logic [3:0] len;
  int num_errors, n_tests;
  sls_line_adapter u_dut (.clk_sys(clk_sys), .reset(reset), .regWrite(regWrite),
    .regRead(regRead), .regChannel(regChannel), .regNum(regNum), .regWData(regWData),
    .regRData(regRData), .regRValid(regRValid), .dsrPin(dsrPin), .ctsPin(ctsPin),
    .carrierPin(carrierPin), .ringPin(ringPin), .txClockPin(txClockPin),
    .rxCharReady(rxCharReady), .rxOverrunSet(rxOverrunSet), .txDataPin(txDataPin),
    .rtsPin(), .dtrPin(dtrPin), .rxRequest(rxRequest), .txRequest(txRequest),
    .controlOut(controlOut), .syncChar(syncChar));
  sls_modem_model u_modem (.clr(clr), .len(len), .txDataPin(txDataPin),
    .txClockPin(txClockPin), .got(got), .done(done));
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic conclude;
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic c, input logic [2:0] n, input logic [7:0] d);
    regChannel = c;
    regNum = n;
    regWData = d;
    regWrite = 1'h1;
    tick(1);
    regWrite = 1'h0;
    tick(1);
  endtask
  task automatic rd(input logic [2:0] n);
    regNum = n;
    regRead = 1'h1;
    tick(1);
    regRead = 1'h0;
    chk("regRValid", 8'h01, {7'h00, regRValid});
    rdv = regRData;
    tick(1);
  endtask
  task automatic t_status;
    rd(REG_STATUS);
    chk("status", 8'hDC, rdv);
    rd(REG_STATUS);
    chk("status reread", 8'hDC, rdv);
    dsrPin = 1'h0;
    carrierPin = 1'h1;
    ringPin = 1'h0;
    tick(5);
    rd(REG_STATUS);
    chk("modem bits", 8'h6C, rdv);
  endtask
  task automatic t_rx;
    wr(CHAN_RX, REG_CONTROL, 8'h02);
    rxCharReady = 1'h1;
    tick(2);
    chk("rxRequest", 8'h01, {7'h00, rxRequest});
    rxOverrunSet = 1'h1;
    tick(1);
    rxOverrunSet = 1'h0;
    rd(REG_STATUS);
    chk("overrun", 8'h6E, rdv);
    wr(CHAN_TX, REG_CONTROL, 8'h00);
    chk("rxRequest off", 8'h00, {7'h00, rxRequest});
    rxCharReady = 1'h0;
  endtask
  // Buffer is filled with transmit off, since then nothing drains it meanwhile.
  task automatic t_tx;
    int i;
    wr(CHAN_RX, REG_CONFIG, 8'hC0);
    wr(CHAN_TX, REG_CHAR4, 8'hFF);
    wr(CHAN_RX, REG_CONTROL, 8'h40);
    for (i = 0; i < 65; i++)
      wr(CHAN_TX, REG_DATA, (i == 0) ? 8'h4A : 8'hFF);
    rd(REG_STATUS);
    chk("full status", 8'h60, rdv);
    chk("txRequest off", 8'h00, {7'h00, txRequest});
    wr(CHAN_TX, REG_CONTROL, 8'hC1);
    for (i = 0; i < 2000 && txRequest !== 1'h1; i++)
      tick(1);
    chk("txRequest", 8'h01, {7'h00, txRequest});
    ctsPin = 1'h0;
    tick(8);
    chk("txRequest no cts", 8'h00, {7'h00, txRequest});
    ctsPin = 1'h1;
    for (i = 0; i < 3000 && rdv[ST_TXUR] !== 1'h1; i++)
      rd(REG_STATUS);
    chk("drained status", 8'h6D, rdv);
    chk("first char", 8'h4A, got);
  endtask
  task automatic t_short;
    int i;
    clr = 1'h1;
    len = 4'h5;
    tick(1);
    clr = 1'h0;
    wr(CHAN_TX, REG_CONFIG, 8'h3F);
    wr(CHAN_TX, REG_DATA, 8'h0A);
    for (i = 0; i < 1000 && done !== 1'h1; i++)
      tick(1);
    chk("short char", 8'h0A, got >> 3);
  endtask
  // Loop-back must hold the line and the buffer; direct connect must send at the slow fixed rate.
  task automatic t_modes;
    int i;
    rd(REG_CONFIG);
    chk("config", 8'h3F, rdv);
    rd(REG_DATA);
    chk("data read", 8'h00, rdv);
    chk("syncChar", 8'h16, syncChar);
    chk("dtrPin on", 8'h01, {7'h00, dtrPin});
    wr(CHAN_RX, REG_CONTROL, 8'h00);
    chk("dtrPin off", 8'h00, {7'h00, dtrPin});
    wr(CHAN_RX, REG_CHAR4, 8'hE9);
    chk("syncChar written", 8'hE9, syncChar);
    wr(CHAN_TX, REG_CONTROL, 8'h45);
    rd(REG_CONTROL);
    chk("control", 8'h45, rdv);
    wr(CHAN_TX, REG_DATA, 8'h00);
    tick(60);
    rd(REG_STATUS);
    chk("loop-back line", 8'h01, {7'h00, txDataPin});
    chk("loop-back held", 8'h00, {7'h00, rdv[ST_TXEMPTY]});
    wr(CHAN_RX, REG_CONTROL, 8'h49);
    for (i = 0; i < 4000 && txDataPin !== 1'h0; i++)
      tick(1);
    tick(200);
    chk("direct bit", 8'h00, {7'h00, txDataPin});
    rd(REG_STATUS);
    chk("direct drained", 8'h01, {7'h00, rdv[ST_TXEMPTY]});
  endtask
  initial
  begin
    reset = 1'h1;
    regWrite = 1'h0;
    regRead = 1'h0;
    regChannel = 1'h0;
    regNum = 3'h0;
    regWData = 8'h00;
    dsrPin = 1'h1;
    ctsPin = 1'h1;
    carrierPin = 1'h0;
    ringPin = 1'h1;
    rxCharReady = 1'h0;
    rxOverrunSet = 1'h0;
    clr = 1'h1;
    len = 4'h8;
    num_errors = 0;
    n_tests = 0;
    tick(6);
    reset = 1'h0;
    clr = 1'h0;
    tick(4);
    t_status();
    t_rx();
    t_tx();
    t_short();
    t_modes();
    conclude();
  end
  initial
  begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule
